// file: logic/issm_mux.sv
// Internal source select multiplexer: a Wishbone slave holding three select registers
// and the multiplexers they steer into PWM, DAC and timer A inputs.
// Assumes internal signals share clk_i; pin inputs are asynchronous and are synchronised here.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "issm_consts.svh"

module issm_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire issm_pkg::issm_pins_t pins_i,
  input wire issm_pkg::issm_internal_t internal_i,
  input wire issm_pkg::issm_adc_slot_t adc_slot_0_i,
  input wire issm_pkg::issm_adc_slot_t adc_slot_1_i,
  output issm_pkg::issm_pwm_pair_t pwm_first_pair_o,
  output issm_pkg::issm_pwm_pair_t pwm_middle_pair_o,
  output logic dac0_sync_o,
  output logic dac1_sync_o,
  output logic timer_a_in1_o,
  output logic timer_a_in2_o,
  output logic timer_a_in3_o
);
  import issm_pkg::*;

  // ********************************************************************
  // Register bus
  // ********************************************************************
  logic [2:0] pwm_first_pair_source_select;
  logic [2:0] pwm_middle_pair_source_select;
  logic [2:0] dac0_sync_source_select;
  logic [2:0] dac1_sync_source_select;
  logic timer_a_in1_select;
  logic timer_a_in2_select;
  logic timer_a_in3_select;
  logic [15:0] pwm_reg_view;
  logic [15:0] dac_reg_view;
  logic [15:0] tmr_reg_view;
  logic [15:0] next_rdata;
  logic bus_req;
  logic wr_pwm;
  logic wr_dac;
  logic wr_tmr;

  // Ack one cycle after the request, then drop it so the master can release.
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land on the edge where the master samples ack, so the cycle completes and commits together.
  assign wr_pwm = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ISSM_PWM_SEL_ADR);
  assign wr_dac = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i == `ISSM_DAC_SEL_ADR);
  assign wr_tmr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && (wb_adr_i == `ISSM_TMR_SEL_ADR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Only the defined field bits are stored, so reserved bits always read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_first_pair_source_select <= `ISSM_PSRC_PIN;
      pwm_middle_pair_source_select <= `ISSM_PSRC_PIN;
    end else if (wr_pwm) begin
      pwm_first_pair_source_select <= wb_dat_i[`ISSM_PWM_FIRST_LSB +: 3];
      pwm_middle_pair_source_select <= wb_dat_i[`ISSM_PWM_MID_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac0_sync_source_select <= `ISSM_DSYNC_INTERVAL_TIMER_0_OUT;
      dac1_sync_source_select <= `ISSM_DSYNC_INTERVAL_TIMER_0_OUT;
    end else if (wr_dac) begin
      dac0_sync_source_select <= wb_dat_i[`ISSM_DAC0_LSB +: 3];
      dac1_sync_source_select <= wb_dat_i[`ISSM_DAC1_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_in1_select <= 1'b0;
      timer_a_in2_select <= 1'b0;
      timer_a_in3_select <= 1'b0;
    end else if (wr_tmr) begin
      if (wb_sel_i[0]) begin
        timer_a_in1_select <= wb_dat_i[`ISSM_TMR_IN1_BIT];
      end
      if (wb_sel_i[1]) begin
        timer_a_in2_select <= wb_dat_i[`ISSM_TMR_IN2_BIT];
        timer_a_in3_select <= wb_dat_i[`ISSM_TMR_IN3_BIT];
      end
    end
  end

  always_comb begin
    pwm_reg_view = `ISSM_RESET_VAL;
    pwm_reg_view[`ISSM_PWM_FIRST_LSB +: 3] = pwm_first_pair_source_select;
    pwm_reg_view[`ISSM_PWM_MID_LSB +: 3] = pwm_middle_pair_source_select;
    dac_reg_view = `ISSM_RESET_VAL;
    dac_reg_view[`ISSM_DAC0_LSB +: 3] = dac0_sync_source_select;
    dac_reg_view[`ISSM_DAC1_LSB +: 3] = dac1_sync_source_select;
    tmr_reg_view = `ISSM_RESET_VAL;
    tmr_reg_view[`ISSM_TMR_IN1_BIT] = timer_a_in1_select;
    tmr_reg_view[`ISSM_TMR_IN2_BIT] = timer_a_in2_select;
    tmr_reg_view[`ISSM_TMR_IN3_BIT] = timer_a_in3_select;
    // Unmapped addresses read zero and are still acknowledged.
    case (wb_adr_i)
      `ISSM_PWM_SEL_ADR: next_rdata = pwm_reg_view;
      `ISSM_DAC_SEL_ADR: next_rdata = dac_reg_view;
      `ISSM_TMR_SEL_ADR: next_rdata = tmr_reg_view;
      default: next_rdata = `ISSM_RESET_VAL;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {16'h0000, next_rdata};
    end
  end

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  issm_pins_t pins_meta;
  issm_pins_t pins_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_i;
      pins_sync <= pins_meta;
    end
  end

  // ********************************************************************
  // PWM pair sources
  // ********************************************************************
  issm_pwm_pair_t next_first_pair;
  issm_pwm_pair_t next_middle_pair;

  // ADC mode forces the pair only outside the limit window; inside it nothing is forced.
  function automatic issm_pwm_pair_t pair_route(input logic [2:0] sel, input logic pin,
      input logic tmr, input issm_adc_slot_t slot, input issm_internal_t inn);
    issm_pwm_pair_t p;
    p = '0;
    case (sel)
      `ISSM_PSRC_PIN: p.pair_source = pin;
      `ISSM_PSRC_TMR: p.pair_source = tmr;
      `ISSM_PSRC_ADC: begin
        if (slot.result > slot.high_limit) begin
          p.force_valid = 1'b1;
          p.even_drive = 1'b0;
          p.odd_drive = 1'b1;
        end else if (slot.result < slot.low_limit) begin
          p.force_valid = 1'b1;
          p.even_drive = 1'b1;
          p.odd_drive = 1'b0;
        end
      end
      `ISSM_PSRC_CMPA: p.pair_source = inn.comparator_a_out;
      `ISSM_PSRC_CMPB: p.pair_source = inn.comparator_b_out;
      default: p = '0;
    endcase
    return p;
  endfunction

  always_comb begin
    next_first_pair = pair_route(pwm_first_pair_source_select, pins_sync.pwm_first_pair_source,
        internal_i.timer_a_channel_0, adc_slot_0_i, internal_i);
    next_middle_pair = pair_route(pwm_middle_pair_source_select, pins_sync.pwm_middle_pair_source,
        internal_i.timer_a_channel_2, adc_slot_1_i, internal_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_first_pair_o <= '0;
      pwm_middle_pair_o <= '0;
    end else begin
      pwm_first_pair_o <= next_first_pair;
      pwm_middle_pair_o <= next_middle_pair;
    end
  end

  // ********************************************************************
  // DAC sync and timer A inputs
  // ********************************************************************
  function automatic logic dsync_route(input logic [2:0] sel, input issm_internal_t inn);
    logic s;
    s = 1'b0;
    case (sel)
      `ISSM_DSYNC_INTERVAL_TIMER_0_OUT: s = inn.interval_timer_0_out;
      `ISSM_DSYNC_INTERVAL_TIMER_1_OUT: s = inn.interval_timer_1_out;
      `ISSM_DSYNC_INTERVAL_TIMER_2_OUT: s = inn.interval_timer_2_out;
      `ISSM_DSYNC_PWM: s = inn.pwm_reload_sync;
      `ISSM_DSYNC_TA0: s = inn.timer_a_channel_0;
      `ISSM_DSYNC_TA1: s = inn.timer_a_channel_1;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac0_sync_o <= 1'b0;
      dac1_sync_o <= 1'b0;
    end else begin
      dac0_sync_o <= dsync_route(dac0_sync_source_select, internal_i);
      dac1_sync_o <= dsync_route(dac1_sync_source_select, internal_i);
    end
  end

  // Reload sync into timer A is only meaningful when both share a clock rate.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_in1_o <= 1'b0;
      timer_a_in2_o <= 1'b0;
      timer_a_in3_o <= 1'b0;
    end else begin
      timer_a_in1_o <= timer_a_in1_select ? internal_i.comparator_a_out : pins_sync.timer_a_channel_1;
      timer_a_in2_o <= timer_a_in2_select ? internal_i.comparator_b_out : pins_sync.timer_a_channel_2;
      timer_a_in3_o <= timer_a_in3_select ? internal_i.pwm_reload_sync : pins_sync.timer_a_channel_3;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  adc_high_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_ADC && adc_slot_0_i.result > adc_slot_0_i.high_limit)
    |=> (pwm_first_pair_o.force_valid && !pwm_first_pair_o.even_drive && pwm_first_pair_o.odd_drive))
    else $error("first pair high limit force wrong");
  adc_low_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_ADC && adc_slot_0_i.result < adc_slot_0_i.low_limit
     && adc_slot_0_i.result <= adc_slot_0_i.high_limit)
    |=> (pwm_first_pair_o.force_valid && pwm_first_pair_o.even_drive && !pwm_first_pair_o.odd_drive))
    else $error("first pair low limit force wrong");
  adc_high_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_ADC && adc_slot_1_i.result > adc_slot_1_i.high_limit)
    |=> (pwm_middle_pair_o.force_valid && !pwm_middle_pair_o.even_drive && pwm_middle_pair_o.odd_drive))
    else $error("middle pair high limit force wrong");
  adc_low_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_ADC && adc_slot_1_i.result < adc_slot_1_i.low_limit
     && adc_slot_1_i.result <= adc_slot_1_i.high_limit)
    |=> (pwm_middle_pair_o.force_valid && pwm_middle_pair_o.even_drive && !pwm_middle_pair_o.odd_drive))
    else $error("middle pair low limit force wrong");
  mid_timer_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_TMR)
    |=> (pwm_middle_pair_o.pair_source == $past(internal_i.timer_a_channel_2)))
    else $error("middle pair timer route wrong");
  reserved_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select > `ISSM_PSRC_CMPB) |=> (pwm_first_pair_o == '0))
    else $error("reserved first pair code not low");
  dac1_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dac1_sync_source_select == `ISSM_DSYNC_PWM) |=> (dac1_sync_o == $past(internal_i.pwm_reload_sync)))
    else $error("dac1 sync route wrong");
  dac0_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dac0_sync_source_select == `ISSM_DSYNC_TA1) |=> (dac0_sync_o == $past(internal_i.timer_a_channel_1)))
    else $error("dac0 sync route wrong");
  tmr_in3_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (timer_a_in3_select) |=> (timer_a_in3_o == $past(internal_i.pwm_reload_sync)))
    else $error("timer input 3 route wrong");
  tmr_in2_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!timer_a_in2_select) |=> (timer_a_in2_o == $past(pins_i.timer_a_channel_2, 3)))
    else $error("timer input 2 pin route wrong");
  tmr_in1_cmp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (timer_a_in1_select) |=> (timer_a_in1_o == $past(internal_i.comparator_a_out)))
    else $error("timer input 1 route wrong");
  write_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_tmr && wb_sel_i[1]) |=> (timer_a_in2_select == $past(wb_dat_i[`ISSM_TMR_IN2_BIT])
     && !wb_ack_o && wb_dat_o[31:16] == 16'h0000))
    else $error("timer select write not stored");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o) |=> (!wb_ack_o))
    else $error("ack held longer than one cycle");
  first_pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_PIN)
    |=> (pwm_first_pair_o.pair_source == $past(pins_sync.pwm_first_pair_source)))
    else $error("first pair pin route wrong");
  first_tmr_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_TMR)
    |=> (pwm_first_pair_o.pair_source == $past(internal_i.timer_a_channel_0)))
    else $error("first pair timer route wrong");
  first_cmpa_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_CMPA)
    |=> (pwm_first_pair_o.pair_source == $past(internal_i.comparator_a_out)))
    else $error("first pair comparator A route wrong");
  first_cmpb_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_first_pair_source_select == `ISSM_PSRC_CMPB)
    |=> (pwm_first_pair_o.pair_source == $past(internal_i.comparator_b_out)))
    else $error("first pair comparator B route wrong");
  mid_pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_PIN)
    |=> (pwm_middle_pair_o.pair_source == $past(pins_sync.pwm_middle_pair_source)))
    else $error("middle pair pin route wrong");
  mid_cmpa_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_CMPA)
    |=> (pwm_middle_pair_o.pair_source == $past(internal_i.comparator_a_out)))
    else $error("middle pair comparator A route wrong");
  mid_cmpb_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select == `ISSM_PSRC_CMPB)
    |=> (pwm_middle_pair_o.pair_source == $past(internal_i.comparator_b_out)))
    else $error("middle pair comparator B route wrong");
  mid_reserved_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwm_middle_pair_source_select > `ISSM_PSRC_CMPB)
    |=> (pwm_middle_pair_o == '0))
    else $error("reserved middle pair code not low");
  dac0_reserved_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dac0_sync_source_select > `ISSM_DSYNC_TA1)
    |=> (!dac0_sync_o))
    else $error("reserved dac0 sync code not low");
  dac1_reserved_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (dac1_sync_source_select > `ISSM_DSYNC_TA1)
    |=> (!dac1_sync_o))
    else $error("reserved dac1 sync code not low");
  tmr_in3_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!timer_a_in3_select)
    |=> (timer_a_in3_o == $past(pins_sync.timer_a_channel_3)))
    else $error("timer input 3 pin route wrong");
  tmr_in1_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!timer_a_in1_select)
    |=> (timer_a_in1_o == $past(pins_sync.timer_a_channel_1)))
    else $error("timer input 1 pin route wrong");
  tmr_in2_cmp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (timer_a_in2_select)
    |=> (timer_a_in2_o == $past(internal_i.comparator_b_out)))
    else $error("timer input 2 comparator route wrong");

endmodule

// file: logic/issm_consts.svh
// Constants for the internal source select multiplexer: offsets, field positions, codes.
// Assumes a Wishbone register bus with 32-bit data and byte addressing.
`ifndef ISSM_CONSTS_SVH
`define ISSM_CONSTS_SVH

// Register word indices; the byte address on the bus is four times the index.
`define ISSM_PWM_SEL_IDX 8'h18
`define ISSM_DAC_SEL_IDX 8'h19
`define ISSM_TMR_SEL_IDX 8'h1a
// Byte addresses, kept at the 8-bit width of the address bus.
`define ISSM_PWM_SEL_ADR (`ISSM_PWM_SEL_IDX << 2)
`define ISSM_DAC_SEL_ADR (`ISSM_DAC_SEL_IDX << 2)
`define ISSM_TMR_SEL_ADR (`ISSM_TMR_SEL_IDX << 2)
`define ISSM_RESET_VAL 16'h0000

// PWM select register field positions.
`define ISSM_PWM_FIRST_LSB 0
`define ISSM_PWM_MID_LSB 3
// DAC select register field positions.
`define ISSM_DAC0_LSB 0
`define ISSM_DAC1_LSB 4
// Timer A select register bit positions.
`define ISSM_TMR_IN1_BIT 4
`define ISSM_TMR_IN2_BIT 8
`define ISSM_TMR_IN3_BIT 12

// PWM pair source codes.
`define ISSM_PSRC_PIN 3'h0
`define ISSM_PSRC_TMR 3'h1
`define ISSM_PSRC_ADC 3'h2
`define ISSM_PSRC_CMPA 3'h3
`define ISSM_PSRC_CMPB 3'h4

// DAC sync source codes.
`define ISSM_DSYNC_INTERVAL_TIMER_0_OUT 3'h0
`define ISSM_DSYNC_INTERVAL_TIMER_1_OUT 3'h1
`define ISSM_DSYNC_INTERVAL_TIMER_2_OUT 3'h2
`define ISSM_DSYNC_PWM 3'h3
`define ISSM_DSYNC_TA0 3'h4
`define ISSM_DSYNC_TA1 3'h5

`endif

// file: logic/issm_pkg.sv
// Types for the internal source select multiplexer.
// Assumes issm_consts.svh is in the include path.
package issm_pkg;

  typedef struct packed {
    logic [11:0] result;
    logic [11:0] high_limit;
    logic [11:0] low_limit;
  } issm_adc_slot_t;

  typedef struct packed {
    logic even_drive;
    logic odd_drive;
    logic force_valid;
    logic pair_source;
  } issm_pwm_pair_t;

  typedef struct packed {
    logic interval_timer_0_out;
    logic interval_timer_1_out;
    logic interval_timer_2_out;
    logic pwm_reload_sync;
    logic timer_a_channel_0;
    logic timer_a_channel_1;
    logic timer_a_channel_2;
    logic comparator_a_out;
    logic comparator_b_out;
  } issm_internal_t;

  typedef struct packed {
    logic timer_a_channel_3;
    logic timer_a_channel_2;
    logic timer_a_channel_1;
    logic pwm_middle_pair_source;
    logic pwm_first_pair_source;
  } issm_pins_t;

endpackage

// file: tb/issm_periph_model.sv
// Behavioural model of the peripherals around the source select multiplexer.
// Assumes the bench sets every source level through src_i and the ADC results directly.
`timescale 1ns/100ps

module issm_periph_model (
  input wire logic clk_i,
  input wire logic [13:0] src_i,
  input wire logic [11:0] res0_i,
  input wire logic [11:0] res1_i,
  output issm_pkg::issm_pins_t pins_o,
  output issm_pkg::issm_internal_t internal_o,
  output issm_pkg::issm_adc_slot_t adc_slot_0_o,
  output issm_pkg::issm_adc_slot_t adc_slot_1_o
);
  import issm_pkg::*;

  // ****************************************
  // Source levels
  // ****************************************
  // Timers and PWM run on clk_i alike, so the reload sync is seen at one rate.
  always_ff @(posedge clk_i) begin
    internal_o <= src_i[8:0];
  end

  // Each peripheral input has exactly one enabled pin feeding it.
  always_ff @(posedge clk_i) begin
    pins_o <= src_i[13:9];
  end

  // Fixed window limits keep the boundary cases easy to place.
  always_ff @(posedge clk_i) begin
    adc_slot_0_o <= {res0_i, 12'h800, 12'h400};
    adc_slot_1_o <= {res1_i, 12'h800, 12'h400};
  end
endmodule

// file: tb/issm_mux_test.sv
// Self-checking bench for the source select multiplexer.
// Assumes the design and peripheral model files are compiled first.
`timescale 1ns/100ps
`include "issm_consts.svh"

module issm_mux_test;
  import issm_pkg::*;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o;
  logic [13:0] src = 14'h0000;
  logic [11:0] res0 = 12'h600;
  logic [11:0] res1 = 12'h600;
  issm_pins_t pins;
  issm_internal_t inner;
  issm_adc_slot_t slot0;
  issm_adc_slot_t slot1;
  issm_pwm_pair_t first_pair;
  issm_pwm_pair_t mid_pair;
  logic dac0;
  logic dac1;
  logic tin1;
  logic tin2;
  logic tin3;
  int err_total = 0;
  int comparisons = 0;

  always #2 clk_i = ~clk_i;

  issm_mux dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins), .internal_i(inner),
    .adc_slot_0_i(slot0), .adc_slot_1_i(slot1), .pwm_first_pair_o(first_pair),
    .pwm_middle_pair_o(mid_pair), .dac0_sync_o(dac0), .dac1_sync_o(dac1),
    .timer_a_in1_o(tin1), .timer_a_in2_o(tin2), .timer_a_in3_o(tin3));

  issm_periph_model model_u (.clk_i(clk_i), .src_i(src), .res0_i(res0), .res1_i(res1),
    .pins_o(pins), .internal_o(inner), .adc_slot_0_o(slot0), .adc_slot_1_o(slot1));

  // ****************************************
  // Reporting and bus access
  // ****************************************
  task automatic results();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until ack is sampled high, since the slave may answer late.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("[FAIL] ack expected 1 seen %b", wb_ack_o);
      results();
    end
  endtask

  // ****************************************
  // Target tables
  // ****************************************
  // Targets: 0 first pair, 1 middle pair, 2 dac0, 3 dac1, 4..6 timer inputs 1..3.
  function automatic int src_idx(input int t, input int c);
    case (t)
      0: return c == 0 ? 9 : c == 1 ? 4 : c == 3 ? 1 : c == 4 ? 0 : -1;
      1: return c == 0 ? 10 : c == 1 ? 2 : c == 3 ? 1 : c == 4 ? 0 : -1;
      2, 3: return c < 6 ? 8 - c : -1;
      4: return c != 0 ? 1 : 11;
      5: return c != 0 ? 0 : 12;
      default: return c != 0 ? 5 : 13;
    endcase
  endfunction

  function automatic logic [15:0] reg_val(input int t, input int c);
    case (t)
      0: return 16'(c) << `ISSM_PWM_FIRST_LSB;
      1: return 16'(c) << `ISSM_PWM_MID_LSB;
      2: return 16'(c) << `ISSM_DAC0_LSB;
      3: return 16'(c) << `ISSM_DAC1_LSB;
      4: return 16'(c) << `ISSM_TMR_IN1_BIT;
      5: return 16'(c) << `ISSM_TMR_IN2_BIT;
      default: return 16'(c) << `ISSM_TMR_IN3_BIT;
    endcase
  endfunction

  function automatic logic [7:0] reg_adr(input int t);
    return t < 2 ? `ISSM_PWM_SEL_IDX << 2 : t < 4 ? `ISSM_DAC_SEL_IDX << 2 : `ISSM_TMR_SEL_IDX << 2;
  endfunction

  function automatic logic out_bit(input int t);
    case (t)
      0: return first_pair.pair_source;
      1: return mid_pair.pair_source;
      2: return dac0;
      3: return dac1;
      4: return tin1;
      5: return tin2;
      default: return tin3;
    endcase
  endfunction

  // Drives the chosen source both ways against all others; reserved codes expect low.
  task automatic probe(input int t, input int c);
    int i;
    logic [15:0] v;
    v = reg_val(t, c);
    wb(reg_adr(t), 1'b1, {16'h0000, v});
    wb(reg_adr(t), 1'b0, 32'h0);
    check("select readback", {16'h0000, v}, rd);
    i = src_idx(t, c);
    for (int s = 0; s < 2; s++) begin
      src <= (i < 0) ? {14{s[0]}} : (s[0] ? 14'h0001 << i : ~(14'h0001 << i));
      // Pin sources pass the model flop, two synchroniser flops and the output flop.
      repeat (6) @(posedge clk_i);
      check("routed source", (i < 0) ? 32'h0 : 32'(s[0]), 32'(out_bit(t)));
    end
  endtask

  task automatic adc(input logic [11:0] r0, input logic [11:0] r1, input logic [2:0] e0, input logic [2:0] e1);
    res0 <= r0;
    res1 <= r1;
    repeat (4) @(posedge clk_i);
    check("first pair drive", 32'(e0), 32'(first_pair[3:1]));
    check("middle pair drive", 32'(e1), 32'(mid_pair[3:1]));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int t = 0; t < 7; t += 2) begin
      wb(reg_adr(t), 1'b0, 32'h0);
      check("reset value", 32'h0, rd);
    end
    wb(8'h70, 1'b1, 32'h0000_ffff);
    wb(8'h70, 1'b0, 32'h0);
    check("unmapped read", 32'h0, rd);
    for (int c = 0; c < 5; c++) begin
      if (c != 2) begin
        probe(0, c);
        probe(1, c);
      end
    end
    for (int c = 0; c < 8; c++) begin
      probe(2, c);
      probe(3, c);
    end
    for (int c = 0; c < 2; c++) begin
      probe(4, c);
      probe(5, c);
      probe(6, c);
    end
    wb(reg_adr(0), 1'b1, 32'h0000_0012);
    adc(12'h801, 12'h3ff, 3'b011, 3'b101);
    adc(12'h3ff, 12'h801, 3'b101, 3'b011);
    adc(12'h800, 12'h400, 3'b000, 3'b000);
    results();
  end
endmodule
